// ==== pkg/ee_pkg.sv ====
// Constants, carrier types and ECC helpers for the two-wire EEPROM slave.
// Assumes a single system clock of 125 MHz sampling the bus pins.
package ee_pkg;
   // ***********************************************************
   // Clock and timing
   // ***********************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int INTERNAL_WRITE_TIME_NS = 5000000;
   localparam int INTERNAL_WRITE_CYCLES =
      INTERNAL_WRITE_TIME_NS / CLK_PERIOD_NS;
   // ***********************************************************
   // Geometry
   // ***********************************************************
   localparam int ARRAY_BYTES = 2048;
   localparam int GROUPS = ARRAY_BYTES / 4;
   localparam int ID_BYTES = 16;
   localparam int CW_BITS = 38;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // ***********************************************************
   // Device select codes and field positions
   // ***********************************************************
   localparam logic [3:0] TYPE_ARRAY = 4'hA;
   localparam logic [3:0] TYPE_ID = 4'hB;
   localparam int ID_LOCK_SELECT_POS = 7;
   localparam int LOCK_DATA_POS = 1;
   localparam int RW_POS = 0;
   // Identity bytes: values are arbitrary
   localparam logic [7:0] ID_BYTE0 = 8'h5A;
   localparam logic [7:0] ID_BYTE1 = 8'h3C;
   localparam logic [7:0] ID_BYTE2 = 8'h96;
   // ***********************************************************
   // Wishbone register map
   // ***********************************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IDEXT = 4'h8;
   localparam int CTRL_UNLOCK_POS = 0;
   localparam int ST_LOCK_POS = 0;
   localparam int ST_BUSY_POS = 1;
   localparam int ST_UNLOCK_POS = 2;
   localparam int IDEXT_OFF_POS = 8;
   localparam logic CTRL_RESET = 1'b0;
   // ***********************************************************
   // Types
   // ***********************************************************
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } ee_evt_t;
   typedef struct packed {
      logic [3:0] adr;
      logic we;
      logic [31:0] dat;
   } ee_wbreq_t;
   typedef enum {PH_DEV, PH_ADDR, PH_DATA} ee_phase_t;
   typedef enum {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} ee_state_t;
   // ***********************************************************
   // Single error correcting code over a four-byte group
   // ***********************************************************
   function automatic logic [CW_BITS-1:0] ecc_enc(logic [31:0] d);
      logic [CW_BITS:0] cw;
      int j;
      logic par;
      cw = '0;
      j = 0;
      for (int p = 1; p <= CW_BITS; p++) begin
         if ((p & (p - 1)) != 0) begin
            cw[p] = d[j];
            j++;
         end
      end
      for (int k = 0; k < 6; k++) begin
         par = 1'b0;
         for (int p = 1; p <= CW_BITS; p++) begin
            if (((p >> k) & 1) == 1) par = par ^ cw[p];
         end
         cw[1 << k] = par;
      end
      return cw[CW_BITS:1];
   endfunction : ecc_enc
   function automatic logic [31:0] ecc_dec(logic [CW_BITS-1:0] c);
      logic [CW_BITS:0] cw;
      logic [5:0] syn;
      logic [31:0] d;
      int j;
      cw = {c, 1'b0};
      syn = '0;
      d = '0;
      j = 0;
      for (int p = 1; p <= CW_BITS; p++) begin
         if (cw[p]) syn = syn ^ 6'(p);
      end
      if (syn != 6'h00 && int'(syn) <= CW_BITS) cw[syn] = ~cw[syn];
      for (int p = 1; p <= CW_BITS; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[j] = cw[p];
            j++;
         end
      end
      return d;
   endfunction : ecc_dec
endpackage : ee_pkg

// ==== design/ee_top.sv ====
// Two-wire serial EEPROM slave: array reads/writes with ECC groups,
// identification page with lock, Wishbone side port for control.
// Assumes SCL and SDA arrive asynchronously; SDA is open drain outside.
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
// Summary of operation
// - Repeated start read select returns addressed byte
// - Each master ack fetches the next byte
// - Read pointer increments, wraps to zero
// - Separate sixteen-byte identification page exists
// - First three page bytes hold identity, writable
// - Page writes use type code 1011
// - Select bit zero, low nibble picks byte
// - Locked page nacks data; extended writes still change it
// - Lock needs select bit one, data bit1
// - Lock is permanent, never cleared
// - Unlock disables 1011 code, enables extended writes
// - Page read uses dummy write then read
// - Single-byte page write acks unless locked
// - Start discards truncated write, stop idles
// - Unprogrammed bytes read back as FFh
// - Reset ignores commands, leaves standby
// - ECC corrects single bit per group
// - Byte write rewrites its whole group
// - Pointer holds last access plus one; after writes it wraps within the page
// - Select code bits 7:4, bit0 read
// - No acknowledge during internal write
module ee_top #(
   parameter int WR_CYCLES = ee_pkg::INTERNAL_WRITE_CYCLES
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Two-wire bus
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O
);
   // ***********************************************************
   // Declarations
   // ***********************************************************
   logic [2:0] scl_s_q, sda_s_q;
   logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
   ee_pkg::ee_evt_t ev;
   ee_pkg::ee_state_t st_q;
   ee_pkg::ee_phase_t ph_q;
   logic [7:0] sh_q, tx_q;
   logic [3:0] cnt_q;
   logic rd_q, id_q, lsel_q, mack_q;
   logic [2:0] blk_q;
   logic [10:0] ptr_q;
   logic [3:0] off_q, idoff_q;
   logic [6:0] pg_q;
   logic [7:0] buf_q [0:15];
   logic [15:0] be_q;
   logic bid_q, lockpend_q, commit_q;
   // Nonvolatile contents as delivered: erased array, identity bytes
   logic [ee_pkg::CW_BITS-1:0] mem_q [0:ee_pkg::GROUPS-1] =
      '{default: ee_pkg::ecc_enc({4{ee_pkg::ERASED_BYTE}})};
   logic [7:0] idpg_q [0:ee_pkg::ID_BYTES-1] = '{
      0: ee_pkg::ID_BYTE0,
      1: ee_pkg::ID_BYTE1,
      2: ee_pkg::ID_BYTE2,
      default: ee_pkg::ERASED_BYTE};
   logic lock_q = 1'b0;
   logic cm_act_q;
   logic [1:0] cm_grp_q;
   logic [31:0] busy_q;
   logic busy;
   logic unlock_q, wb_idw_q;
   logic [3:0] wb_idoff_q;
   logic [7:0] wb_iddat_q;
   ee_pkg::ee_wbreq_t wb;
   logic type_arr, type_id, sel_ok;
   logic [31:0] rd_grp, cm_old, cm_new;
   logic [7:0] rd_byte;
   logic [8:0] cm_idx;

   assign busy = (busy_q != '0) || cm_act_q;
   assign wb = '{adr: WB_ADR_I, we: WB_WE_I, dat: WB_DAT_I};

   // ***********************************************************
   // Pin synchronisers and bus condition detection
   // ***********************************************************
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], SCL_IN};
         sda_s_q <= {sda_s_q[1:0], SDA_IN};
         if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end

   always_comb begin
      ev.start = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
      ev.stop = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
      ev.rise = scl_f_q && !scl_p_q;
      ev.fall = !scl_f_q && scl_p_q;
   end

   // ***********************************************************
   // Decode of received byte and read data path
   // ***********************************************************
   always_comb begin
      type_arr = sh_q[7:4] == ee_pkg::TYPE_ARRAY;
      type_id = sh_q[7:4] == ee_pkg::TYPE_ID && !unlock_q;
      sel_ok = (type_arr || type_id) && !busy;
      rd_grp = ee_pkg::ecc_dec(mem_q[ptr_q[10:2]]);
      rd_byte = rd_grp[8*ptr_q[1:0] +: 8];
   end

   // ***********************************************************
   // Protocol engine
   // ***********************************************************
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         st_q <= ee_pkg::S_IDLE;
         ph_q <= ee_pkg::PH_DEV;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         cnt_q <= 4'h0;
         rd_q <= 1'b0;
         id_q <= 1'b0;
         lsel_q <= 1'b0;
         mack_q <= 1'b0;
         blk_q <= 3'h0;
         ptr_q <= 11'h000;
         off_q <= 4'h0;
         idoff_q <= 4'h0;
         pg_q <= 7'h00;
         be_q <= 16'h0000;
         bid_q <= 1'b0;
         lockpend_q <= 1'b0;
         commit_q <= 1'b0;
         SDA_OE <= 1'b0;
         SDA_OUT <= 1'b0;
      end else begin
         commit_q <= 1'b0;
         if (ev.start) begin
            st_q <= ee_pkg::S_RX;
            ph_q <= ee_pkg::PH_DEV;
            cnt_q <= 4'h0;
            be_q <= 16'h0000;
            lockpend_q <= 1'b0;
            SDA_OE <= 1'b0;
         end else if (ev.stop) begin
            st_q <= ee_pkg::S_IDLE;
            SDA_OE <= 1'b0;
            if (be_q != 16'h0000 || lockpend_q) commit_q <= 1'b1;
         end else begin
            unique case (st_q)
               ee_pkg::S_IDLE: begin
               end
               ee_pkg::S_RX: begin
                  if (ev.rise && cnt_q < 4'h8) begin
                     sh_q <= {sh_q[6:0], sda_f_q};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (ev.fall && cnt_q == 4'h8) begin
                     st_q <= ee_pkg::S_ACK;
                     unique case (ph_q)
                        ee_pkg::PH_DEV: begin
                           SDA_OE <= sel_ok;
                           id_q <= type_id;
                           blk_q <= sh_q[3:1];
                           rd_q <= sh_q[ee_pkg::RW_POS];
                        end
                        ee_pkg::PH_ADDR: begin
                           SDA_OE <= 1'b1;
                           if (id_q) begin
                              lsel_q <= sh_q[ee_pkg::ID_LOCK_SELECT_POS];
                              idoff_q <= sh_q[3:0];
                              off_q <= sh_q[3:0];
                           end else begin
                              ptr_q <= {blk_q, sh_q};
                              pg_q <= {blk_q, sh_q[7:4]};
                              off_q <= sh_q[3:0];
                           end
                        end
                        ee_pkg::PH_DATA: begin
                           if (id_q && lsel_q) begin
                              SDA_OE <= 1'b1;
                              if (sh_q[ee_pkg::LOCK_DATA_POS])
                                 lockpend_q <= 1'b1;
                           end else if (id_q && lock_q) begin
                              SDA_OE <= 1'b0;
                           end else begin
                              SDA_OE <= 1'b1;
                              buf_q[off_q] <= sh_q;
                              be_q[off_q] <= 1'b1;
                              bid_q <= id_q;
                              off_q <= off_q + 4'h1;
                              if (!id_q)
                                 ptr_q <= {pg_q, off_q + 4'h1};
                           end
                        end
                     endcase
                  end
               end
               ee_pkg::S_ACK: begin
                  if (ev.fall) begin
                     if (!SDA_OE) begin
                        st_q <= ee_pkg::S_IDLE;
                     end else if (ph_q == ee_pkg::PH_DEV && rd_q) begin
                        st_q <= ee_pkg::S_TX;
                        cnt_q <= 4'h0;
                        if (id_q) begin
                           tx_q <= idpg_q[idoff_q];
                           SDA_OE <= !idpg_q[idoff_q][7];
                           idoff_q <= idoff_q + 4'h1;
                        end else begin
                           tx_q <= rd_byte;
                           SDA_OE <= !rd_byte[7];
                           ptr_q <= ptr_q + 11'h001;
                        end
                     end else begin
                        SDA_OE <= 1'b0;
                        st_q <= ee_pkg::S_RX;
                        cnt_q <= 4'h0;
                        ph_q <= (ph_q == ee_pkg::PH_DEV) ?
                           ee_pkg::PH_ADDR : ee_pkg::PH_DATA;
                     end
                  end
               end
               ee_pkg::S_TX: begin
                  if (ev.fall) begin
                     if (cnt_q == 4'h7) begin
                        SDA_OE <= 1'b0;
                        st_q <= ee_pkg::S_MACK;
                     end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        SDA_OE <= !tx_q[6];
                        cnt_q <= cnt_q + 4'h1;
                     end
                  end
               end
               ee_pkg::S_MACK: begin
                  if (ev.rise) begin
                     mack_q <= !sda_f_q;
                  end else if (ev.fall) begin
                     if (mack_q) begin
                        st_q <= ee_pkg::S_TX;
                        cnt_q <= 4'h0;
                        if (id_q) begin
                           tx_q <= idpg_q[idoff_q];
                           SDA_OE <= !idpg_q[idoff_q][7];
                           idoff_q <= idoff_q + 4'h1;
                        end else begin
                           tx_q <= rd_byte;
                           SDA_OE <= !rd_byte[7];
                           ptr_q <= ptr_q + 11'h001;
                        end
                     end else begin
                        st_q <= ee_pkg::S_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // ***********************************************************
   // Internal write: group read-modify-write, id page, lock
   // ***********************************************************
   always_comb begin
      cm_idx = {pg_q, cm_grp_q};
      cm_old = ee_pkg::ecc_dec(mem_q[cm_idx]);
      for (int b = 0; b < 4; b++) begin
         cm_new[8*b +: 8] = be_q[{cm_grp_q, 2'(b)}] ?
            buf_q[{cm_grp_q, 2'(b)}] : cm_old[8*b +: 8];
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         cm_act_q <= 1'b0;
         cm_grp_q <= 2'h0;
         busy_q <= '0;
      end else begin
         if (busy_q != '0) busy_q <= busy_q - 32'd1;
         if (commit_q) begin
            busy_q <= 32'(WR_CYCLES);
            if (lockpend_q) lock_q <= 1'b1;
            if (bid_q && !lock_q) begin
               for (int i = 0; i < ee_pkg::ID_BYTES; i++) begin
                  if (be_q[i]) idpg_q[i] <= buf_q[i];
               end
            end else if (!bid_q && be_q != 16'h0000) begin
               cm_act_q <= 1'b1;
               cm_grp_q <= 2'h0;
            end
         end else if (cm_act_q) begin
            if (be_q[{cm_grp_q, 2'h0} +: 4] != 4'h0)
               mem_q[cm_idx] <= ee_pkg::ecc_enc(cm_new);
            cm_grp_q <= cm_grp_q + 2'h1;
            if (cm_grp_q == 2'h3) cm_act_q <= 1'b0;
         end
         if (wb_idw_q) idpg_q[wb_idoff_q] <= wb_iddat_q;
      end
   end

   // ***********************************************************
   // Wishbone register slave
   // ***********************************************************
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
         unlock_q <= ee_pkg::CTRL_RESET;
         wb_idw_q <= 1'b0;
         wb_idoff_q <= 4'h0;
         wb_iddat_q <= 8'h00;
      end else begin
         WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
         wb_idw_q <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
         if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
            if (wb.we && wb.adr == ee_pkg::ADDR_CTRL && WB_SEL_I[0])
               unlock_q <= wb.dat[ee_pkg::CTRL_UNLOCK_POS];
            if (wb.we && wb.adr == ee_pkg::ADDR_IDEXT && unlock_q &&
                WB_SEL_I[1:0] == 2'h3) begin
               wb_idw_q <= 1'b1;
               wb_idoff_q <= wb.dat[ee_pkg::IDEXT_OFF_POS +: 4];
               wb_iddat_q <= wb.dat[7:0];
            end
            if (!wb.we && wb.adr == ee_pkg::ADDR_CTRL)
               WB_DAT_O[ee_pkg::CTRL_UNLOCK_POS] <= unlock_q;
            if (!wb.we && wb.adr == ee_pkg::ADDR_STATUS) begin
               WB_DAT_O[ee_pkg::ST_LOCK_POS] <= lock_q;
               WB_DAT_O[ee_pkg::ST_BUSY_POS] <= busy;
               WB_DAT_O[ee_pkg::ST_UNLOCK_POS] <= unlock_q;
            end
         end
      end
   end

   // ***********************************************************
   // Assertions
   // ***********************************************************
   sequence devsel_end_s;
      st_q == ee_pkg::S_RX && ev.fall && cnt_q == 4'h8 &&
         ph_q == ee_pkg::PH_DEV && !ev.start && !ev.stop;
   endsequence
   sequence commit_s;
      commit_q && !bid_q && be_q != 16'h0000 && !lockpend_q;
   endsequence

   busy_no_ack_a: assert property (@(posedge MCLK) disable iff (RESET)
      devsel_end_s and busy |=> !SDA_OE)
      else $error("Device acknowledged while busy");
   devsel_ack_a: assert property (@(posedge MCLK) disable iff (RESET)
      devsel_end_s and !busy and (sh_q[7:4] == ee_pkg::TYPE_ARRAY)
      |=> SDA_OE)
      else $error("Array select not acknowledged");
   unlock_ign_a: assert property (@(posedge MCLK) disable iff (RESET)
      devsel_end_s and unlock_q and (sh_q[7:4] == ee_pkg::TYPE_ID)
      |=> !SDA_OE)
      else $error("Page code answered after unlock");
   locked_nack_a: assert property (@(posedge MCLK) disable iff (RESET)
      st_q == ee_pkg::S_RX && ev.fall && cnt_q == 4'h8 && !ev.start &&
      !ev.stop && ph_q == ee_pkg::PH_DATA && id_q && !lsel_q && lock_q
      |=> !SDA_OE && $stable(be_q))
      else $error("Locked page data acknowledged");
   lock_sticky_a: assert property (@(posedge MCLK) disable iff (RESET)
      lock_q |=> lock_q)
      else $error("Lock was cleared");
   start_discard_a: assert property (@(posedge MCLK) disable iff (RESET)
      ev.start |=> be_q == 16'h0000 && !lockpend_q && !commit_q)
      else $error("Start did not discard pending write");
   ptr_wrap_a: assert property (@(posedge MCLK) disable iff (RESET)
      st_q == ee_pkg::S_MACK && ev.fall && mack_q && !id_q &&
      !ev.start && !ev.stop && ptr_q == 11'h7FF |=> ptr_q == 11'h000)
      else $error("Pointer did not wrap to zero");
   group_rmw_a: assert property (@(posedge MCLK) disable iff (RESET)
      commit_s |=> cm_act_q [*4] ##1 !cm_act_q && busy)
      else $error("Group rewrite sequence wrong");
   standby_a: assert property (@(posedge MCLK) disable iff (RESET)
      st_q == ee_pkg::S_IDLE && !ev.start |=> !SDA_OE)
      else $error("Bus driven in standby");
endmodule : ee_top

// ==== verif/ee_mst.sv ====
// Bus master model driving the two-wire clock and data lines.
// Assumes a pull-up on the resolved data line; clock idles high.
`timescale 1ns/1ps
module ee_mst (
   // Clock and bus
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sdo
);
   // ****************
   // Bit and frame tasks
   // ****************
   localparam int H = 26;
   initial begin
      scl = 1'b1;
      sdo = 1'b1;
   end
   task automatic hw(input int n);
      repeat (n) @(posedge mclk);
   endtask : hw
   task automatic bt(input logic b, output logic r);
      sdo <= b;
      hw(H / 2);
      scl <= 1'b1;
      hw(H);
      r = sda;
      scl <= 1'b0;
      hw(H / 2);
   endtask : bt
   task automatic sta();
      sdo <= 1'b1;
      hw(H / 2);
      scl <= 1'b1;
      hw(H);
      sdo <= 1'b0;
      hw(H);
      scl <= 1'b0;
      hw(H / 2);
   endtask : sta
   task automatic sto();
      sdo <= 1'b0;
      hw(H / 2);
      scl <= 1'b1;
      hw(H);
      sdo <= 1'b1;
      hw(H);
   endtask : sto
   task automatic wby(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bt(d[i], r);
      bt(1'b1, r);
      ack = ~r;
   endtask : wby
   task automatic rby(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
      bt(~mack, r);
   endtask : rby
endmodule : ee_mst

// ==== verif/tb_top.sv ====
// Testbench: array reads and writes, id page, lock, control port.
// Assumes the master model as far side and a pull-up on data.
`timescale 1ns/1ps
module tb_top;
   // ****************
   // Harness
   // ****************
   localparam int WR = 2000;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, q;
   logic ack, oe, so, scl, sdo, a;
   logic [7:0] d;
   wire logic sda = sdo & ~(oe & ~so);
   int error_cnt = 0;
   int checked = 0;
   int cyc_cnt = 0;
   always #4 mclk = ~mclk;
   ee_mst m (.mclk(mclk), .sda(sda), .scl(scl), .sdo(sdo));
   ee_top #(.WR_CYCLES(WR)) dut (.MCLK(mclk), .RESET(reset),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(so), .SDA_OE(oe),
      .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack));
   task automatic finish_test();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask : chk
   task automatic wb(input logic [3:0] ad, input logic w,
      input logic [31:0] dt);
      @(posedge mclk);
      cyc <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= dt;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      @(posedge mclk);
   endtask : wb
   task automatic wr(input logic [7:0] b, input logic e);
      m.wby(b, a);
      chk(32'(a), 32'(e));
   endtask : wr
   task automatic wf(input logic [7:0] dv, ad, dt, input logic e);
      m.sta();
      wr(dv, 1'b1);
      wr(ad, 1'b1);
      wr(dt, e);
      m.sto();
   endtask : wf
   task automatic rd(input logic [7:0] dv, ad, input int n,
      input logic [7:0] e [3]);
      if (dv[0] == 1'b0) begin
         m.sta();
         wr(dv, 1'b1);
         wr(ad, 1'b1);
      end
      m.sta();
      wr(dv | 8'h01, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.rby(i < n - 1, d);
         chk(32'(d), 32'(e[i]));
      end
      m.sto();
   endtask : rd
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      wb(4'h4, 1'b0, 32'h0);
      chk(q & 32'h7, 32'h0);
      wb(4'hC, 1'b0, 32'h0);
      chk(q, 32'h0);
      m.sta();
      wr(8'h90, 1'b0);
      m.sto();
   endtask : t_reset
   task automatic t_array();
      rd(8'hA0, 8'h10, 1, '{8'hFF, 8'h00, 8'h00});
      wf(8'hAE, 8'hFF, 8'h12, 1'b1);
      m.sta();
      wr(8'hA0, 1'b0);
      m.sto();
      m.hw(WR);
      rd(8'hAE, 8'hFD, 2, '{8'hFF, 8'hFF, 8'h00});
      rd(8'hA1, 8'h00, 2, '{8'h12, 8'hFF, 8'h00});
   endtask : t_array
   task automatic t_id();
      rd(8'hB0, 8'h70, 3, '{ee_pkg::ID_BYTE0, ee_pkg::ID_BYTE1,
         ee_pkg::ID_BYTE2});
      m.sta();
      wr(8'hB0, 1'b1);
      wr(8'h05, 1'b1);
      wr(8'h77, 1'b1);
      m.sta();
      m.sto();
      rd(8'hB0, 8'h05, 1, '{8'hFF, 8'h00, 8'h00});
      m.sta();
      wr(8'hB0, 1'b1);
      wr(8'h0F, 1'b1);
      wr(8'h11, 1'b1);
      wr(8'h22, 1'b1);
      m.sto();
      m.hw(WR);
      rd(8'hB0, 8'h0F, 1, '{8'h11, 8'h00, 8'h00});
      rd(8'hB0, 8'h00, 1, '{8'h22, 8'h00, 8'h00});
   endtask : t_id
   task automatic t_lock();
      wf(8'hB0, 8'h80, 8'h02, 1'b1);
      m.hw(WR);
      wb(4'h4, 1'b0, 32'h0);
      chk(32'(q[0]), 32'h1);
      wf(8'hB0, 8'h00, 8'h99, 1'b0);
      m.hw(WR);
      rd(8'hB0, 8'h00, 1, '{8'h22, 8'h00, 8'h00});
      wb(4'h0, 1'b1, 32'h1);
      wb(4'h4, 1'b0, 32'h0);
      chk(32'(q[2]), 32'h1);
      m.sta();
      wr(8'hB1, 1'b0);
      m.sto();
      wb(4'h8, 1'b1, 32'h0344);
      wb(4'h0, 1'b1, 32'h0);
      rd(8'hB0, 8'h03, 1, '{8'h44, 8'h00, 8'h00});
   endtask : t_lock
   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_array();
      t_id();
      t_lock();
      finish_test();
   end
   always @(posedge mclk) begin
      cyc_cnt++;
      if (cyc_cnt == 90000) begin
         error_cnt++;
         finish_test();
      end
   end
endmodule : tb_top
